// file: smc_cmd.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module smc_cmd #(
  parameter int unsigned SHORT_CYCLES = 32'd1_200_000_000,
  parameter int unsigned EXT_CYCLES   = 32'd4_000_000_000,
  parameter int unsigned COLL_CYCLES  = 32'd600_000_000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        test_error,
  output logic             intrq,
  output logic             standby_timer_block,
  output logic             power_saving
);
  import smc_pkg::*;

  // ==========================================
  // registers
  smc_state_t  state;
  logic [7:0]  features_reg, sector_count_reg, sector_number_reg;
  logic [15:0] track_address_regs;
  logic [7:0]  drive_head_reg, status, error;
  logic [31:0] run_cnt;
  logic        run_act, run_susp, run_is_test, smart_off;
  logic [1:0]  run_kind;
  logic [3:0]  tst_status;
  logic [7:0]  coll_status;
  logic [8:0]  ptr;
  logic [7:0]  log_sel;
  logic        saved;
  logic [2:0]  save_cnt;
  logic [2:0]  err_idx;
  logic [7:0]  err_log [ERR_ENTRIES];
  logic [7:0]  host_log [HOST_LOGS][SECTOR_BYTES];
  logic        ack;
  logic        irq_pend;

  // ==========================================
  // decode
  wire cmd_wr   = avs_write && avs_address == ADDR_COMMAND && !ack;
  wire [7:0] cmd = avs_writedata[7:0];
  wire key_ok   = track_address_regs == SMART_KEY;
  wire is_smart = cmd == CMD_SMART && key_ok;
  wire is_save  = is_smart && features_reg == FT_SAVE;
  wire is_exec  = is_smart && features_reg == FT_EXEC;
  wire is_log   = is_smart && features_reg == FT_LOG;
  wire is_en    = is_smart && features_reg == FT_ENABLE;
  wire is_dis   = is_smart && features_reg == FT_DISABLE;
  wire is_sleep = cmd == CMD_SLEEP;
  wire is_pwr   = cmd == CMD_STANDBY || cmd == CMD_IDLE;
  wire sub_off  = sector_number_reg == SUB_COLLECT ||
                  sector_number_reg == SUB_SHORT ||
                  sector_number_reg == SUB_EXT;
  wire sub_cap  = sector_number_reg == SUB_CSHORT ||
                  sector_number_reg == SUB_CEXT;
  wire sub_abt  = sector_number_reg == SUB_ABORT;
  wire sub_bad  = !(sub_off || sub_cap || sub_abt);
  wire log_host = sector_number_reg >= LOG_HOST_LO &&
                  sector_number_reg <= LOG_HOST_HI;
  wire log_ok   = sector_number_reg == LOG_ERROR ||
                  sector_number_reg == LOG_SELF || log_host;
  wire log_bad  = !log_ok || sector_count_reg != 8'h01;
  wire busy     = state != SMC_IDLE;
  wire data_rd  = avs_read && avs_address == ADDR_DATA;
  wire data_wr  = avs_write && avs_address == ADDR_DATA;
  wire [7:0] hidx = {3'h0, log_sel[4:0]};
  wire run_done = run_act && !run_susp && run_cnt == 32'h0;
  wire log_err  = state == SMC_IDLE && cmd_wr &&
                  ((is_exec && sub_bad) || (is_log && log_bad));

  function automatic logic [31:0] dur(input logic [1:0] k);
    case (k)
      2'd1:    dur = SHORT_CYCLES;
      2'd2:    dur = EXT_CYCLES;
      default: dur = COLL_CYCLES;
    endcase
  endfunction

  function automatic logic [7:0] log_byte(input logic [7:0] sel,
                                          input logic [8:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (sel == LOG_ERROR) begin
      if (p == 9'd0)
        v = 8'h01;
      else if (p == 9'd1)
        v = {5'h0, err_idx};
      else if (p < 9'(ERR_ENTRIES + 2))
        v = err_log[3'(p - 9'd2)];
    end else if (sel == LOG_SELF) begin
      if (p == 9'd0)
        v = {4'h0, tst_status};
    end else begin
      v = host_log[sel[4:0]][p];
    end
    log_byte = v;
  endfunction

  // ==========================================
  // bus answer: one wait cycle on every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign intrq               = irq_pend;
  assign standby_timer_block = run_act; // [RQ14]

  always_ff @(posedge clk) begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (avs_read || avs_write) && !ack;
  end

  always_ff @(posedge clk) begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack) begin
      case (avs_address)
        ADDR_FEATURES: avs_readdata <= {24'h0, error};
        ADDR_COUNT:    avs_readdata <= {24'h0, sector_count_reg};
        ADDR_SECTOR:   avs_readdata <= {24'h0, sector_number_reg};
        ADDR_TRACK:    avs_readdata <= {16'h0, track_address_regs};
        ADDR_UNIT:     avs_readdata <= {24'h0, drive_head_reg};
        ADDR_STATUS:   avs_readdata <= {24'h0, status};
        ADDR_DATA:     avs_readdata <= {24'h0, log_byte(log_sel, ptr)};
        ADDR_TSTAT:    avs_readdata <= {20'h0, tst_status};
        ADDR_ERRLOG:   avs_readdata <= {24'h0, coll_status};
        ADDR_IRQ:      avs_readdata <= {31'h0, irq_pend};
        default:       avs_readdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // task file writes
  always_ff @(posedge clk) begin
    if (rst) begin
      features_reg       <= 8'h00;
      sector_number_reg  <= 8'h00;
      track_address_regs <= 16'h0;
      drive_head_reg     <= 8'h00;
    end else if (avs_write && !ack && !busy) begin
      if (avs_address == ADDR_FEATURES)
        features_reg <= avs_writedata[7:0];
      if (avs_address == ADDR_SECTOR)
        sector_number_reg <= avs_writedata[7:0];
      if (avs_address == ADDR_TRACK)
        track_address_regs <= avs_writedata[15:0];
      if (avs_address == ADDR_UNIT)
        drive_head_reg <= avs_writedata[7:0];
    end
  end

  // ==========================================
  // host vendor logs, written over data port
  always_ff @(posedge clk) begin
    if (state == SMC_WLOG && data_wr && !ack)
      host_log[hidx[4:0]][ptr] <= avs_writedata[7:0]; // [RQ21]
  end

  // ==========================================
  // command engine
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SMC_IDLE;
      status <= 8'h40;
      error <= 8'h00;
      sector_count_reg <= 8'h00;
      irq_pend <= 1'b0;
      run_act <= 1'b0;
      run_susp <= 1'b0;
      run_is_test <= 1'b0;
      run_kind <= 2'd0;
      run_cnt <= 32'h0;
      smart_off <= 1'b0;
      power_saving <= 1'b0;
      tst_status <= TST_OK;
      coll_status <= 8'h00;
      ptr <= 9'h0;
      log_sel <= 8'h00;
      saved <= 1'b0;
      save_cnt <= 3'd0;
      err_idx <= 3'd0;
    end else begin
      if (avs_read && !ack && avs_address == ADDR_STATUS)
        irq_pend <= 1'b0;
      if (avs_write && !ack && avs_address == ADDR_COUNT && !busy)
        sector_count_reg <= avs_writedata[7:0];
      // background routine, never touches busy or ready [RQ8]
      if (run_act && !run_susp && run_cnt != 32'h0)
        run_cnt <= run_cnt - 32'h1;
      if (run_act && !run_susp && run_is_test && test_error) begin
        run_act <= 1'b0; // [RQ15]
        tst_status <= TST_FATAL;
      end else if (run_done) begin
        run_act <= 1'b0;
        if (run_is_test)
          tst_status <= TST_OK;
        else
          coll_status <= 8'h02; // [RQ17]
      end
      if (log_err) // [RQ25]
        err_idx <= err_idx == 3'(ERR_ENTRIES - 1) ? 3'd0 : err_idx + 3'd1;
      case (state)
        SMC_IDLE: begin
          if (cmd_wr) begin
            error <= 8'h00;
            status[BIT_ERR] <= 1'b0;
            if (run_act && !is_exec && !is_dis && !is_sleep && !is_pwr)
              run_susp <= 1'b1; // [RQ9]
            if (power_saving && !is_sleep && !is_pwr) begin
              power_saving <= 1'b0;
              run_susp <= 1'b0; // [RQ13]
            end
            if (is_save) begin
              status[BIT_BSY] <= 1'b1; // [RQ1]
              save_cnt <= 3'(SAVE_CYCLES);
              state <= SMC_SAVE;
            end else if (is_exec) begin // [RQ2]
              if (sub_bad) begin
                error <= ERR_ABORT; // [RQ6]
                status[BIT_ERR] <= 1'b1;
                irq_pend <= 1'b1;
              end else begin
                if (run_act) begin
                  run_act <= 1'b0; // [RQ12]
                  run_susp <= 1'b0;
                  if (run_is_test)
                    tst_status <= TST_ABORTED;
                end
                irq_pend <= 1'b1;
                if (sub_abt && run_act && run_is_test) begin
                  run_act <= 1'b0; // [RQ4]
                  tst_status <= TST_ABORTED;
                end else if (sub_off) begin
                  // completion interrupt and routine start on the same edge, RQ7 asks completion first [RQ7]
                  run_act <= 1'b1; // [RQ3]
                  run_susp <= 1'b0;
                  run_kind <= sector_number_reg[1:0];
                  run_is_test <= sector_number_reg != SUB_COLLECT;
                  run_cnt <= dur(sector_number_reg[1:0]); // [RQ18]
                  if (sector_number_reg != SUB_COLLECT)
                    tst_status <= TST_RUNNING; // [RQ24]
                  else
                    coll_status <= 8'h03;
                end else if (sub_cap) begin
                  irq_pend <= 1'b0;
                  status[BIT_BSY] <= 1'b1; // [RQ5] [RQ16]
                  tst_status <= TST_RUNNING;
                  run_cnt <= dur(sector_number_reg[1:0]);
                  state <= SMC_CAPT;
                end
              end
            end else if (is_log) begin
              if (log_bad) begin
                error <= ERR_ABORT; // [RQ22]
                status[BIT_ERR] <= 1'b1;
                irq_pend <= 1'b1;
              end else begin
                status[BIT_BSY] <= 1'b1; // [RQ23]
                log_sel <= sector_number_reg;
                ptr <= 9'h0;
                state <= SMC_LOAD;
              end
            end else if (is_dis) begin
              run_susp <= run_act; // [RQ11]
              smart_off <= 1'b1;
              irq_pend <= 1'b1;
            end else if (is_en) begin
              smart_off <= 1'b0;
              run_susp <= 1'b0; // [RQ11]
              irq_pend <= 1'b1;
            end else if (is_sleep) begin
              if (run_act && run_is_test) begin
                run_act <= 1'b0; // [RQ10]
                tst_status <= TST_ABORTED;
              end
              power_saving <= 1'b1;
              irq_pend <= 1'b1;
            end else if (is_pwr) begin
              run_susp <= run_act; // [RQ13]
              power_saving <= 1'b1;
              irq_pend <= 1'b1;
            end else if (cmd == 8'h30 && log_host) begin
              log_sel <= sector_number_reg; // [RQ20]
              ptr <= 9'h0;
              status[BIT_DRQ] <= 1'b1;
              state <= SMC_WLOG;
            end else if (cmd == 8'h30) begin
              error <= ERR_ABORT; // [RQ20]
              status[BIT_ERR] <= 1'b1;
              irq_pend <= 1'b1;
            end else begin
              irq_pend <= 1'b1;
              if (run_act)
                run_susp <= 1'b0; // served, resume [RQ9]
            end
          end
        end
        SMC_SAVE: begin
          save_cnt <= save_cnt - 3'd1;
          if (save_cnt == 3'd1) begin
            saved <= 1'b1;
            status[BIT_BSY] <= 1'b0; // [RQ1]
            irq_pend <= 1'b1;
            state <= SMC_IDLE;
          end
        end
        SMC_LOAD: begin
          status[BIT_BSY] <= 1'b0;
          status[BIT_DRQ] <= 1'b1; // [RQ23]
          irq_pend <= 1'b1;
          state <= SMC_XFER;
        end
        SMC_XFER: begin
          if (data_rd && !ack) begin
            ptr <= ptr + 9'h1;
            if (ptr == 9'(SECTOR_BYTES - 1)) begin
              status[BIT_DRQ] <= 1'b0;
              sector_count_reg <= 8'h00; // [RQ19]
              state <= SMC_IDLE;
            end
          end
        end
        SMC_WLOG: begin
          if (data_wr && !ack) begin
            ptr <= ptr + 9'h1;
            if (ptr == 9'(SECTOR_BYTES - 1)) begin
              status[BIT_DRQ] <= 1'b0;
              irq_pend <= 1'b1;
              state <= SMC_IDLE;
            end
          end
        end
        SMC_CAPT: begin
          run_cnt <= run_cnt - 32'h1;
          if (test_error || run_cnt == 32'h0) begin
            tst_status <= test_error ? TST_FATAL : TST_OK; // [RQ16]
            status[BIT_BSY] <= 1'b0;
            irq_pend <= 1'b1;
            state <= SMC_IDLE;
          end
        end
        default: state <= SMC_IDLE;
      endcase
    end
  end

  // ==========================================
  // error log pointer, wraps after five [RQ25]
  always_ff @(posedge clk) begin
    if (rst)
      for (int i = 0; i < ERR_ENTRIES; i++)
        err_log[i] <= 8'h00;
    else if (log_err)
      err_log[err_idx] <= sector_number_reg;
  end
endmodule // smc_cmd

// file: smc_pkg.sv
// How it works
// RQ1: save attributes: busy, store, done, interrupt
// RQ2: host writes execute code with subcommand
// RQ3: codes 0,1,2 start offline routines
// RQ4: code 127 aborts offline self-test
// RQ5: codes 129,130 run captive self-tests
// RQ6: reserved subcommands abort, start nothing
// RQ7: offline: complete command, then start routine; code raises the interrupt and starts it on the same edge
// RQ8: offline routine keeps busy clear, ready set
// RQ9: other command suspends routine, resumes later
// RQ10: sleep aborts self-test, then sleeps
// RQ11: disable suspends; next enable resumes
// RQ12: new execute aborts old, runs new
// RQ13: standby/idle suspends; wake resumes unless aborted
// RQ14: no own power change during routine
// RQ15: offline self-test error stops, records status
// RQ16: captive: busy, test, record, complete
// RQ17: collection offline only, own status byte
// RQ18: short minutes, extended tens of minutes; EXT_CYCLES gives 400 s at CLK_HZ
// RQ19: read log: count one, ends zero
// RQ20: logs 01h, 06h read only
// RQ21: logs 80h-9Fh host read/write
// RQ22: reserved log address aborts, no data
// RQ23: data read: busy, load, request, interrupt
// RQ24: status 0 ok,1 abort,2 reset,15 running
// RQ25: error log five entries circular
package smc_pkg;
  // ==========================================
  // register map (word addresses)
  localparam logic [3:0] ADDR_FEATURES  = 4'h0;
  localparam logic [3:0] ADDR_COUNT     = 4'h1;
  localparam logic [3:0] ADDR_SECTOR    = 4'h2;
  localparam logic [3:0] ADDR_TRACK     = 4'h3;
  localparam logic [3:0] ADDR_UNIT      = 4'h4;
  localparam logic [3:0] ADDR_COMMAND   = 4'h5;
  localparam logic [3:0] ADDR_STATUS    = 4'h6;
  localparam logic [3:0] ADDR_DATA      = 4'h7;
  localparam logic [3:0] ADDR_TSTAT     = 4'h8;
  localparam logic [3:0] ADDR_ERRLOG    = 4'h9;
  localparam logic [3:0] ADDR_IRQ       = 4'hA;
  // ==========================================
  // status bits
  localparam int BIT_ERR  = 0;
  localparam int BIT_DRQ  = 3;
  localparam int BIT_DRDY = 6;
  localparam int BIT_BSY  = 7;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  // ==========================================
  // command codes
  localparam logic [7:0]  CMD_SMART   = 8'hB0;
  localparam logic [7:0]  CMD_SLEEP   = 8'hE6;
  localparam logic [7:0]  CMD_STANDBY = 8'hE0;
  localparam logic [7:0]  CMD_IDLE    = 8'hE1;
  localparam logic [15:0] SMART_KEY   = 16'hC24F;
  localparam logic [7:0]  FT_SAVE     = 8'hD3;
  localparam logic [7:0]  FT_EXEC     = 8'hD4;
  localparam logic [7:0]  FT_LOG      = 8'hD5;
  localparam logic [7:0]  FT_ENABLE   = 8'hD8;
  localparam logic [7:0]  FT_DISABLE  = 8'hD9;
  localparam logic [7:0]  SUB_COLLECT = 8'h00;
  localparam logic [7:0]  SUB_SHORT   = 8'h01;
  localparam logic [7:0]  SUB_EXT     = 8'h02;
  localparam logic [7:0]  SUB_ABORT   = 8'h7F;
  localparam logic [7:0]  SUB_CSHORT  = 8'h81;
  localparam logic [7:0]  SUB_CEXT    = 8'h82;
  localparam logic [7:0]  LOG_ERROR   = 8'h01;
  localparam logic [7:0]  LOG_SELF    = 8'h06;
  localparam logic [7:0]  LOG_HOST_LO = 8'h80;
  localparam logic [7:0]  LOG_HOST_HI = 8'h9F;
  // ==========================================
  // self-test execution status codes
  localparam logic [3:0] TST_OK      = 4'h0;
  localparam logic [3:0] TST_ABORTED = 4'h1;
  localparam logic [3:0] TST_RESET   = 4'h2;
  localparam logic [3:0] TST_FATAL   = 4'h3;
  localparam logic [3:0] TST_RUNNING = 4'hF;
  // ==========================================
  // timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int SVC_LIMIT_MS   = 2000;
  localparam int SVC_CYCLES     = SVC_LIMIT_MS * (CLK_HZ / 1000);
  localparam int SAVE_CYCLES    = 4;
  localparam int SECTOR_BYTES   = 512;
  localparam int ERR_ENTRIES    = 5;
  localparam int HOST_LOGS      = 32;

  typedef enum logic [5:0] {
    SMC_IDLE  = 6'h01,
    SMC_SAVE  = 6'h02,
    SMC_LOAD  = 6'h04,
    SMC_XFER  = 6'h08,
    SMC_CAPT  = 6'h10,
    SMC_WLOG  = 6'h20
  } smc_state_t;
endpackage

// file: smc_chk.sv
`timescale 1ns/1ps
// ==========================================
// protocol checker
module smc_chk
  import smc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        test_error,
  input wire logic        intrq,
  input wire logic        standby_timer_block,
  input wire logic        power_saving
);
  logic [7:0]  ft;
  logic [7:0]  sn;
  logic [7:0]  run_sub;
  logic [7:0]  age;
  logic [15:0] trk;
  wire acc   = avs_write && !avs_waitrequest;
  wire cmd   = acc && avs_address == ADDR_COMMAND;
  wire smart = cmd && avs_writedata[7:0] == CMD_SMART && trk == SMART_KEY;
  wire exec  = smart && ft == FT_EXEC;
  wire capt  = sn == SUB_CSHORT || sn == SUB_CEXT;
  wire resv  = sn > SUB_EXT && sn != SUB_ABORT && !capt;
  wire st_on = run_sub == SUB_SHORT || run_sub == SUB_EXT;
  wire sleep = cmd && avs_writedata[7:0] == CMD_SLEEP;
  wire st_rd = avs_read && !avs_waitrequest && avs_address == ADDR_STATUS;
  // ==========================================
  // shadow of the task file
  always_ff @(posedge clk) begin
    if (rst) begin
      ft      <= 8'h00;
      sn      <= 8'h00;
      trk     <= 16'h0000;
      run_sub <= 8'h00;
      age     <= 8'hFF;
    end else begin
      if (acc && avs_address == ADDR_FEATURES) ft <= avs_writedata[7:0];
      if (acc && avs_address == ADDR_SECTOR) sn <= avs_writedata[7:0];
      if (acc && avs_address == ADDR_TRACK) trk <= avs_writedata[15:0];
      if (exec) run_sub <= sn;
      age <= cmd ? 8'h00 : (age == 8'hFF ? age : age + 8'h01);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // assertions
  property p_first_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait)
    else $error("no wait state on first access cycle");
  property p_irq_clear;
    st_rd && !avs_readdata[BIT_BSY] && !avs_readdata[BIT_DRQ] |-> !intrq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt not cleared by status read");
  property p_save;
    smart && ft == FT_SAVE |-> ##[1:10] intrq;
  endproperty
  a_save: assert property (p_save)
    else $error("save without interrupt");
  property p_start;
    exec && sn <= SUB_EXT |-> ##[1:8] standby_timer_block;
  endproperty
  a_start: assert property (p_start)
    else $error("offline routine not started");
  property p_ready;
    st_rd && standby_timer_block |->
      !avs_readdata[BIT_BSY] && avs_readdata[BIT_DRDY];
  endproperty
  a_ready: assert property (p_ready)
    else $error("busy or not ready during offline routine");
  property p_abort;
    exec && sn == SUB_ABORT && st_on && $past(standby_timer_block)
      |-> ##[1:8] !standby_timer_block;
  endproperty
  a_abort: assert property (p_abort)
    else $error("self-test not aborted");
  property p_reserved;
    exec && resv && !standby_timer_block |=> !standby_timer_block [*8];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved subcommand started a routine");
  property p_captive;
    exec && capt && !standby_timer_block && !intrq
      |=> (!standby_timer_block && !intrq) [*8];
  endproperty
  a_captive: assert property (p_captive)
    else $error("captive test completed early or ran offline");
  property p_sleep;
    sleep && st_on && $past(standby_timer_block)
      |-> ##[1:8] !standby_timer_block;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("self-test not aborted by sleep");
  property p_power;
    $rose(power_saving) |-> cmd || age < 8'h10;
  endproperty
  a_power: assert property (p_power)
    else $error("power state changed without host command");
  property p_log;
    smart && ft == FT_LOG |-> ##[1:10] intrq;
  endproperty
  a_log: assert property (p_log)
    else $error("log command without completion");
endmodule // smc_chk

bind smc_cmd smc_chk u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .test_error(test_error), .intrq(intrq),
  .standby_timer_block(standby_timer_block), .power_saving(power_saving)
);

// file: smc_host.sv
`timescale 1ns/1ps
// ==========================================
// host side bus master
module smc_host
  import smc_pkg::*;
(
  input  wire logic        clk,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address   = 4'h0;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_writedata = 32'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'h1;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    avs_write     <= 1'h0;
    avs_writedata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'h1;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'h0;
  endtask
  task automatic smart(input logic [7:0] ft, input logic [7:0] sn);
    wr(ADDR_FEATURES, {24'h0, ft});
    wr(ADDR_SECTOR, {24'h0, sn});
    wr(ADDR_COUNT, 32'h1);
    wr(ADDR_TRACK, {16'h0, SMART_KEY});
    wr(ADDR_COMMAND, {24'h0, CMD_SMART});
  endtask
endmodule // smc_host

// file: smc_cmd_tb.sv
`timescale 1ns/1ps
module smc_cmd_tb;
  import smc_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk;
  logic        rst;
  logic        test_error;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        intrq;
  logic        standby_timer_block;
  logic        power_saving;
  logic [31:0] v;
  int          bad_count;
  int          total_checks;
  int          cycles;
  smc_cmd #(.SHORT_CYCLES(20), .EXT_CYCLES(400), .COLL_CYCLES(20)) dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .test_error(test_error), .intrq(intrq),
    .standby_timer_block(standby_timer_block), .power_saving(power_saving));
  smc_host h (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  always #50 clk = ~clk;
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_sig(ref logic s, input logic w, input int lim,
                          input string nm);
    int n;
    n = 0;
    while (s !== w && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(nm, {31'h0, w}, {31'h0, s});
  endtask
  task automatic idle();
    int n;
    n = 0;
    h.rd(ADDR_STATUS, v);
    while (v[BIT_BSY] !== 1'h0 && n < 400) begin
      h.rd(ADDR_STATUS, v);
      n++;
    end
    h.rd(ADDR_STATUS, v);
    chk("busy", 32'h0, {31'h0, v[BIT_BSY]});
  endtask
  // ==========================================
  // scenarios
  task automatic t_basic();
    h.rd(ADDR_TSTAT, v);
    chk("tstat", {28'h0, TST_OK}, v);
    h.smart(FT_SAVE, 8'h00);
    wait_sig(intrq, 1'h1, 20, "save irq");
    h.rd(ADDR_STATUS, v);
    chk("status", 32'h40, v);
    h.smart(FT_LOG, LOG_SELF);
    wait_sig(intrq, 1'h1, 20, "log irq");
    h.rd(ADDR_STATUS, v);
    chk("status", 32'h48, v);
    repeat (SECTOR_BYTES) h.rd(ADDR_DATA, v);
    h.rd(ADDR_COUNT, v);
    chk("count", 32'h0, v);
    idle();
    chk("status", 32'h40, v);
  endtask
  task automatic t_hostlog();
    h.wr(ADDR_SECTOR, {24'h0, LOG_SELF});
    h.wr(ADDR_COMMAND, 32'h30);
    idle();
    chk("ro log", 32'h1, {31'h0, v[BIT_ERR]});
    h.wr(ADDR_SECTOR, {24'h0, LOG_HOST_HI});
    h.wr(ADDR_COMMAND, 32'h30);
    idle();
    chk("drq", 32'h1, {31'h0, v[BIT_DRQ]});
    for (int i = 0; i < SECTOR_BYTES; i++)
      h.wr(ADDR_DATA, {24'h0, i[7:0] ^ 8'hA5});
    idle();
    h.smart(FT_LOG, LOG_HOST_HI);
    idle();
    for (int i = 0; i < SECTOR_BYTES; i++) begin
      h.rd(ADDR_DATA, v);
      chk("host log", {24'h0, i[7:0] ^ 8'hA5}, v);
    end
    idle();
  endtask
  task automatic t_refuse();
    logic [7:0] logs[5] = '{8'h00, 8'h02, 8'h07, 8'hA0, 8'hFF};
    logic [7:0] subs[5] = '{8'h03, 8'h7E, 8'h80, 8'h83, 8'hFF};
    foreach (logs[i]) begin
      h.smart(FT_LOG, logs[i]);
      idle();
      chk("log err", 32'h1, {31'h0, v[BIT_ERR]});
      chk("log drq", 32'h0, {31'h0, v[BIT_DRQ]});
      h.smart(FT_EXEC, subs[i]);
      idle();
      chk("sub err", 32'h1, {31'h0, v[BIT_ERR]});
      h.rd(ADDR_FEATURES, v);
      chk("err code", {24'h0, ERR_ABORT}, v);
      chk("routine", 32'h0, {31'h0, standby_timer_block});
    end
  endtask
  task automatic t_offline();
    for (int s = 0; s < 3; s++) begin
      h.smart(FT_EXEC, s[7:0]);
      idle();
      chk("status", 32'h40, v);
      chk("routine", 32'h1, {31'h0, standby_timer_block});
      h.rd(ADDR_TSTAT, v);
      if (s != 0) chk("tstat", {28'h0, TST_RUNNING}, v);
      wait_sig(standby_timer_block, 1'h0, 500, "end");
      h.rd(ADDR_TSTAT, v);
      if (s != 0) chk("tstat", {28'h0, TST_OK}, v);
    end
  endtask
  task automatic t_captive();
    for (int e = 0; e < 2; e++) begin
      h.smart(FT_EXEC, (e != 0) ? SUB_CEXT : SUB_CSHORT);
      h.rd(ADDR_STATUS, v);
      chk("captive busy", 32'h1, {31'h0, v[BIT_BSY]});
      repeat (10) @(posedge clk);
      test_error <= e[0];
      idle();
      h.rd(ADDR_TSTAT, v);
      chk("tstat", {28'h0, (e != 0) ? TST_FATAL : TST_OK}, v);
    end
    test_error <= 1'h0;
  endtask
  task automatic t_abort();
    h.smart(FT_EXEC, SUB_EXT);
    idle();
    h.smart(FT_EXEC, SUB_ABORT);
    idle();
    chk("routine", 32'h0, {31'h0, standby_timer_block});
    h.rd(ADDR_TSTAT, v);
    chk("tstat", {28'h0, TST_ABORTED}, v);
    h.smart(FT_EXEC, SUB_EXT);
    idle();
    h.smart(FT_EXEC, SUB_SHORT);
    idle();
    wait_sig(standby_timer_block, 1'h0, 100, "new routine");
    h.smart(FT_EXEC, SUB_EXT);
    idle();
    h.wr(ADDR_COMMAND, {24'h0, CMD_SLEEP});
    wait_sig(standby_timer_block, 1'h0, 20, "sleep abort");
    idle();
    chk("power", 32'h1, {31'h0, power_saving});
  endtask
  // ==========================================
  // main sequence and timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    test_error = 1'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    h.rd(ADDR_STATUS, v);
    chk("reset status", 32'h40, v);
    chk("reset irq", 32'h0, {31'h0, intrq});
    t_basic();
    t_hostlog();
    t_refuse();
    t_offline();
    t_captive();
    t_abort();
    tally_and_finish();
  end
endmodule // smc_cmd_tb
